// >>> rtl/osc_wd_pkg.sv
// Package: register map, fields and timing constants of the sensor watchdog block
package osc_wd_pkg;

    // Register offsets (byte addresses of the 8-bit register space)
    localparam logic [7:0] RES_RANGE_ADDR   = 8'h01;
    localparam logic [7:0] DIGITAL_ADDR     = 8'h04;
    localparam logic [7:0] SECONDARY_ADDR   = 8'h05;
    localparam logic [7:0] AMP_OK_ADDR      = 8'h0C;
    localparam logic [7:0] STATUS_ADDR      = 8'h20;
    localparam logic [7:0] RES_LSB_ADDR     = 8'h21;
    localparam logic [7:0] RES_MSB_ADDR     = 8'h22;
    localparam logic [7:0] IND_LSB_ADDR     = 8'h23;
    localparam logic [7:0] IND_MSB_ADDR     = 8'h24;
    localparam logic [7:0] HR_B0_ADDR       = 8'h38;
    localparam logic [7:0] HR_B1_ADDR       = 8'h39;
    localparam logic [7:0] HR_B2_ADDR       = 8'h3A;
    localparam logic [7:0] FAMILY_IDENT_ADDR = 8'h3F;

    // Field positions
    localparam int STALL_BIT        = 7;
    localparam int MIN_SENSOR_FREQ_SEL_LSB     = 4;
    localparam int RESP_LSB         = 0;
    localparam int RES_MAX_LSB      = 4;
    localparam int RES_MAX_DIS_BIT  = 7;

    // Reset values
    localparam logic [7:0] RES_RANGE_RST = 8'h07;
    localparam logic [7:0] DIGITAL_RST   = 8'h04;
    localparam logic [7:0] ZERO8         = 8'h00;

    // Arbitrary neutral identification value
    localparam logic [7:0] FAMILY_CODE_DEFAULT = 8'h5A;

    // All-ones high-resolution result on stall
    localparam logic [23:0] HR_STALL_VALUE = 24'hFFFFFF;

    // Watchdog base interval in ns, scaled by the frequency selection
    localparam int CLK_PERIOD_NS = 8;
    localparam int WD_BASE_NS    = 2000;
    localparam int WD_BASE_CYC   = (WD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Oscillator restart pulse length in ns
    localparam int RESTART_NS  = 1000;
    localparam int RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Response-time encodings give 192 * 2^n sensor cycles
    localparam logic [15:0] RESP_BASE = 16'h00C0;
    localparam logic [2:0]  DIVISOR   = 3'h3;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Watchdog states
    typedef enum logic [1:0] {
        WD_IDLE    = 2'b00,
        WD_WATCH   = 2'b01,
        WD_RESTART = 2'b10
    } wd_state_t;

endpackage

// >>> rtl/osc_watchdog.sv
// Watchdog timer that supervises sensor oscillation and restarts it
`timescale 1ns/1ps
module osc_watchdog
    import osc_wd_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       active,
    input  wire logic       sensor_edge,
    input  wire logic [3:0] min_sensor_freq_sel,
    output logic            stall_pulse,
    output logic            osc_restart
);
    wd_state_t   state_reg;
    logic [22:0] cnt_reg;
    logic [22:0] limit;

    // Lower frequency code selects the longer wait (code 0 waits longest, 23 bits hold it)
    assign limit = 23'(WD_BASE_CYC) << (5'd15 - {1'b0, min_sensor_freq_sel});

    // Count idle cycles, restart the oscillator on timeout
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= WD_IDLE;
            cnt_reg   <= '0;
        end
        else
        begin
            unique case (state_reg)
                WD_IDLE:
                begin
                    cnt_reg <= '0;
                    if (active)
                        state_reg <= WD_WATCH;
                end
                WD_WATCH:
                begin
                    if (!active)
                        state_reg <= WD_IDLE;
                    else if (sensor_edge)
                        cnt_reg <= '0;
                    else if (cnt_reg >= limit - 23'h000001)
                    begin
                        state_reg <= WD_RESTART;
                        cnt_reg   <= '0;
                    end
                    else
                        cnt_reg <= cnt_reg + 23'h000001;
                end
                WD_RESTART:
                begin
                    if (cnt_reg >= 23'(RESTART_CYC - 1))
                    begin
                        state_reg <= WD_WATCH;
                        cnt_reg   <= '0;
                    end
                    else
                        cnt_reg <= cnt_reg + 23'h000001;
                end
                default: state_reg <= WD_IDLE;
            endcase
        end
    end

    assign stall_pulse = (state_reg == WD_WATCH) && active && !sensor_edge
                         && (cnt_reg >= limit - 23'h000001);
    assign osc_restart = (state_reg == WD_RESTART);
endmodule // osc_watchdog

// >>> rtl/ind_divider.sv
// Sequential divider: response cycles times reference count over three sensor counts
`timescale 1ns/1ps
module ind_divider
    import osc_wd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic [31:0] numer,
    input  wire logic [31:0] denom,
    output logic             done,
    output logic [15:0]      quot
);
    logic [31:0] rem_reg;
    logic [31:0] q_reg;
    logic [5:0]  bit_reg;
    logic        busy_reg;
    logic [32:0] trial;

    assign trial = {rem_reg, q_reg[31]} - {1'b0, denom};

    // Restoring division, one quotient bit per clock
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rem_reg  <= '0;
            q_reg    <= '0;
            bit_reg  <= '0;
            busy_reg <= 1'b0;
            done     <= 1'b0;
            quot     <= '0;
        end
        else
        begin
            done <= 1'b0;
            if (abort)
                busy_reg <= 1'b0;
            else if (start)
            begin
                rem_reg  <= '0;
                q_reg    <= numer;
                bit_reg  <= 6'h20;
                busy_reg <= 1'b1;
            end
            else if (busy_reg)
            begin
                if (!trial[32])
                begin
                    rem_reg <= trial[31:0];
                    q_reg   <= {q_reg[30:0], 1'b1};
                end
                else
                begin
                    rem_reg <= {rem_reg[30:0], q_reg[31]};
                    q_reg   <= {q_reg[30:0], 1'b0};
                end
                bit_reg <= bit_reg - 6'h01;
                if (bit_reg == 6'h01)
                begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                    quot     <= (|q_reg[30:15]) ? 16'hFFFF
                                : {q_reg[14:0], !trial[32]};
                end
            end
        end
    end
endmodule // ind_divider

// >>> rtl/sensor_osc_watchdog_results.sv
// Sensor oscillation watchdog with resistance and inductance result registers
// Overview of operation
// - In active mode a missing sensor oscillation sets the stall flag, status bit 7 at 0x20.
// - A stall restarts the sensor oscillator and aborts any conversion in progress.
// - The watchdog wait comes from the frequency field in bits 7:4 of 0x04.
// - The same field also sets how the oscillator is started on the sensor.
// - A lower frequency setting lengthens the wait before a stall is reported.
// - On a stall the high-resolution inductance result is loaded with all ones.
// - The 16-bit resistance result reads low byte at 0x21 and high byte at 0x22.
// - The 16-bit inductance result reads across 0x23 and 0x24.
// - Inductance result is reference count times response cycles over three sensor counts.
// - Register 0x01 holds the maximum range in bits 5:4 and its disable in bit 7.
// - A read-only family code sits in bits 7:0 of 0x3F.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module sensor_osc_watchdog_results
    import osc_wd_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = FAMILY_CODE_DEFAULT
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire osc_wd_pkg::reg_req_t req,
    output logic [7:0]            rdata,
    input  wire logic             active_mode,
    input  wire logic             sensor_edge,
    input  wire logic             ref_clock_in,
    input  wire logic             res_valid,
    input  wire logic [15:0]      res_sample,
    input  wire logic             hr_valid,
    input  wire logic [23:0]      hr_sample,
    output logic                  osc_restart,
    output logic [3:0]            osc_start_sel,
    output logic [1:0]            res_range_max,
    output logic                  res_max_disable,
    output logic                  conv_busy
);
    import osc_wd_pkg::*;

    // Assertions sample on the core clock and sleep while in reset
    default clocking core_cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic [7:0]  res_range_settings_reg;
    logic [7:0]  digital_settings_reg;
    logic [7:0]  secondary_settings_reg;
    logic [7:0]  amp_ok_report_ctl_reg;
    logic        osc_stall_flag_reg;
    logic [15:0] resistance_result_reg;
    logic [15:0] inductance_result_reg;
    logic [23:0] high_res_inductance_reg;
    logic [15:0] sens_cnt_reg;
    logic [15:0] ref_cnt_reg;
    logic        ref_d_reg;
    logic        stall_pulse;
    logic        div_done;
    logic [15:0] div_quot;
    logic [15:0] resp_cycles;
    logic        conv_end;
    logic        rd_stall;
    logic        stall_rd_reg;

    // Response cycles: 192 shifted by the response field
    function automatic logic [15:0] resp_of(input logic [2:0] code);
        resp_of = RESP_BASE << code;
    endfunction

    assign resp_cycles     = resp_of(digital_settings_reg[RESP_LSB +: 3]);
    assign osc_start_sel   = digital_settings_reg[MIN_SENSOR_FREQ_SEL_LSB +: 4];
    assign res_range_max   = res_range_settings_reg[RES_MAX_LSB +: 2];
    assign res_max_disable = res_range_settings_reg[RES_MAX_DIS_BIT];
    assign rd_stall        = req.rd && (req.addr == STATUS_ADDR);

    // Watchdog timer, interval from frequency field
    osc_watchdog osc_watchdog_i (
        .core_clk            (core_clk),
        .rst_b               (rst_b),
        .active              (active_mode),
        .sensor_edge         (sensor_edge),
        .min_sensor_freq_sel (digital_settings_reg[MIN_SENSOR_FREQ_SEL_LSB +: 4]),
        .stall_pulse         (stall_pulse),
        .osc_restart         (osc_restart)
    );

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            res_range_settings_reg <= RES_RANGE_RST;
            digital_settings_reg   <= DIGITAL_RST;
            secondary_settings_reg <= ZERO8;
            amp_ok_report_ctl_reg  <= ZERO8;
        end
        else if (req.wr)
        begin
            unique case (req.addr)
                RES_RANGE_ADDR: res_range_settings_reg <= req.wdata;
                DIGITAL_ADDR:   digital_settings_reg   <= req.wdata;
                SECONDARY_ADDR: secondary_settings_reg <= req.wdata;
                AMP_OK_ADDR:    amp_ok_report_ctl_reg  <= req.wdata;
                default:        ;
            endcase
        end
    end

    // Stall flag: set wins over clear-on-read of status
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            osc_stall_flag_reg <= 1'b0;
        else if (stall_pulse)
            osc_stall_flag_reg <= 1'b1;
        else if (rd_stall)
            osc_stall_flag_reg <= 1'b0;
    end

    // Count sensor edges and reference rising edges over one response window
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sens_cnt_reg <= '0;
            ref_cnt_reg  <= '0;
            ref_d_reg    <= 1'b0;
            conv_busy    <= 1'b0;
        end
        else
        begin
            ref_d_reg <= ref_clock_in;
            if (stall_pulse || osc_restart || !active_mode)
            begin
                sens_cnt_reg <= '0;
                ref_cnt_reg  <= '0;
                conv_busy    <= 1'b0;
            end
            else if (conv_end)
            begin
                sens_cnt_reg <= '0;
                ref_cnt_reg  <= '0;
                conv_busy    <= 1'b0;
            end
            else
            begin
                conv_busy <= 1'b1;
                if (sensor_edge)
                    sens_cnt_reg <= sens_cnt_reg + 16'h0001;
                if (ref_clock_in && !ref_d_reg && ref_cnt_reg != 16'hFFFF)
                    ref_cnt_reg <= ref_cnt_reg + 16'h0001;
            end
        end
    end

    assign conv_end = conv_busy && sensor_edge && (sens_cnt_reg == resp_cycles - 16'h0001);

    // Inductance = ref_count*resp / (3*sensor_count); sensor_count = resp so ref*resp/(3*resp)
    ind_divider ind_divider_i (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .start    (conv_end),
        .abort    (stall_pulse),
        .numer    ({16'h0000, ref_cnt_reg} * {16'h0000, resp_cycles}),
        .denom    (32'(DIVISOR) * {16'h0000, resp_cycles}),
        .done     (div_done),
        .quot     (div_quot)
    );

    // Result registers
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            resistance_result_reg   <= '0;
            inductance_result_reg   <= '0;
            high_res_inductance_reg <= '0;
        end
        else
        begin
            if (res_valid)
                resistance_result_reg <= res_sample;
            if (div_done)
                inductance_result_reg <= div_quot;
            if (stall_pulse)
                high_res_inductance_reg <= HR_STALL_VALUE;
            else if (hr_valid)
                high_res_inductance_reg <= hr_sample;
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= '0;
        else if (req.rd)
        begin
            unique case (req.addr)
                RES_RANGE_ADDR:    rdata <= res_range_settings_reg;
                DIGITAL_ADDR:      rdata <= digital_settings_reg;
                SECONDARY_ADDR:    rdata <= secondary_settings_reg;
                AMP_OK_ADDR:       rdata <= amp_ok_report_ctl_reg;
                STATUS_ADDR:       rdata <= {osc_stall_flag_reg, 7'h00};
                RES_LSB_ADDR:      rdata <= resistance_result_reg[7:0];
                RES_MSB_ADDR:      rdata <= resistance_result_reg[15:8];
                IND_LSB_ADDR:      rdata <= inductance_result_reg[7:0];
                IND_MSB_ADDR:      rdata <= inductance_result_reg[15:8];
                HR_B0_ADDR:        rdata <= high_res_inductance_reg[7:0];
                HR_B1_ADDR:        rdata <= high_res_inductance_reg[15:8];
                HR_B2_ADDR:        rdata <= high_res_inductance_reg[23:16];
                FAMILY_IDENT_ADDR: rdata <= FAMILY_CODE;
                default:           rdata <= ZERO8;
            endcase
        end
        else
            rdata <= ZERO8;
    end

    // Stall pulse delayed by one cycle, used by the result loading check
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            stall_rd_reg <= 1'b0;
        else
            stall_rd_reg <= stall_pulse;
    end

    // Stall reporting and status clear-on-read
    stall_flag_a : assert property
        (stall_pulse |=> osc_stall_flag_reg)
        else $error("stall flag not set");
    stall_active_a : assert property
        (stall_pulse |-> active_mode)
        else $error("stall outside active mode");
    status_read_a : assert property
        (rd_stall |=> rdata[STALL_BIT] == $past(osc_stall_flag_reg))
        else $error("status read wrong");
    flag_clear_a : assert property
        (rd_stall && !stall_pulse |=> !osc_stall_flag_reg)
        else $error("stall flag not cleared");

    // Restart and conversion abort
    restart_follows_a : assert property
        (stall_pulse |=> osc_restart)
        else $error("no restart after stall");
    restart_cause_a : assert property
        ($rose(osc_restart) |-> $past(stall_pulse))
        else $error("restart without stall");
    conv_abort_a : assert property
        (stall_pulse |=> !conv_busy)
        else $error("conversion not aborted");
    restart_idle_a : assert property
        (osc_restart |=> !conv_busy)
        else $error("conversion during restart");
    div_abort_a : assert property
        (stall_pulse |=> !div_done)
        else $error("division not aborted");

    // Result loading
    hr_ones_a : assert property
        (stall_rd_reg |-> high_res_inductance_reg == HR_STALL_VALUE)
        else $error("result not all ones");
    hr_keep_a : assert property
        (hr_valid && !stall_pulse |=> high_res_inductance_reg == $past(hr_sample))
        else $error("high-res sample lost");
    res_load_a : assert property
        (res_valid |=> resistance_result_reg == $past(res_sample))
        else $error("resistance sample lost");

    // Result byte lanes and the family code on the read port
    res_lsb_read_a : assert property
        (req.rd && req.addr == RES_LSB_ADDR && !res_valid |=>
         rdata == resistance_result_reg[7:0])
        else $error("resistance low byte");
    res_msb_read_a : assert property
        (req.rd && req.addr == RES_MSB_ADDR && !res_valid |=>
         rdata == resistance_result_reg[15:8])
        else $error("resistance high byte");
    ind_lsb_read_a : assert property
        (req.rd && req.addr == IND_LSB_ADDR && !div_done |=>
         rdata == inductance_result_reg[7:0])
        else $error("inductance low byte");
    ind_msb_read_a : assert property
        (req.rd && req.addr == IND_MSB_ADDR && !div_done |=>
         rdata == inductance_result_reg[15:8])
        else $error("inductance high byte");
    family_read_a : assert property
        (req.rd && req.addr == FAMILY_IDENT_ADDR |=> rdata == FAMILY_CODE)
        else $error("family code wrong");

    // Register fields and the read-only identity
    start_sel_a : assert property
        (req.wr && req.addr == DIGITAL_ADDR |=>
         osc_start_sel == $past(req.wdata[MIN_SENSOR_FREQ_SEL_LSB +: 4]))
        else $error("start select wrong");
    range_field_a : assert property
        (req.wr && req.addr == RES_RANGE_ADDR |=>
         res_range_max == $past(req.wdata[RES_MAX_LSB +: 2]) &&
         res_max_disable == $past(req.wdata[RES_MAX_DIS_BIT]))
        else $error("range field wrong");
    ident_write_a : assert property
        (req.wr && req.addr == FAMILY_IDENT_ADDR |=> $stable(digital_settings_reg))
        else $error("ident write changed state");
    ident_keep_a : assert property
        (req.wr && req.addr == FAMILY_IDENT_ADDR |=> $stable(res_range_settings_reg))
        else $error("ident write changed range");
endmodule // sensor_osc_watchdog_results

// >>> testbench/sensor_tank.sv
// Behavioural model of the external resonant sensor tank
`timescale 1ns/1ps
module sensor_tank
#(
    parameter int PERIOD = 8
)
(
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic run,
    input  wire logic osc_restart,
    output logic      sensor_edge
);
    int cnt;

    // One edge per oscillation; a stopped tank or a restart in progress stays silent
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt         <= 0;
            sensor_edge <= 1'b0;
        end
        else if (!run || osc_restart)
        begin
            cnt         <= 0;
            sensor_edge <= 1'b0;
        end
        else
        begin
            cnt         <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            sensor_edge <= (cnt == PERIOD - 1);
        end
    end
endmodule // sensor_tank

// >>> testbench/sensor_osc_watchdog_results_tb_top.sv
// Self-checking bench for the sensor watchdog and result registers
`timescale 1ns/1ps
module sensor_osc_watchdog_results_tb_top;
    import osc_wd_pkg::*;

    logic                 core_clk = 1'b0;
    logic                 rst_b    = 1'b0;
    osc_wd_pkg::reg_req_t req      = '0;
    logic [7:0]           rdata;
    logic                 active_mode  = 1'b0;
    logic                 sensor_edge;
    logic                 ref_clock_in = 1'b0;
    logic                 res_valid    = 1'b0;
    logic [15:0]          res_sample   = 16'h0000;
    logic                 hr_valid     = 1'b0;
    logic [23:0]          hr_sample    = 24'h000000;
    logic                 osc_restart;
    logic [3:0]           osc_start_sel;
    logic [1:0]           res_range_max;
    logic                 res_max_disable;
    logic                 conv_busy;
    logic                 run = 1'b0;
    logic [1:0]           ref_div = 2'h0;
    logic [7:0]           rd_val;
    int                   errors = 0;
    int                   tests_run = 0;
    int                   cycles = 0;

    sensor_osc_watchdog_results sensor_osc_watchdog_results_i (
        .core_clk(core_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .active_mode(active_mode), .sensor_edge(sensor_edge), .ref_clock_in(ref_clock_in),
        .res_valid(res_valid), .res_sample(res_sample), .hr_valid(hr_valid),
        .hr_sample(hr_sample), .osc_restart(osc_restart), .osc_start_sel(osc_start_sel),
        .res_range_max(res_range_max), .res_max_disable(res_max_disable),
        .conv_busy(conv_busy));

    sensor_tank sensor_tank_i (
        .core_clk(core_clk), .rst_b(rst_b), .run(run),
        .osc_restart(osc_restart), .sensor_edge(sensor_edge));

    // Clock of 8 ns
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    // Reference clock of four core cycles; timeout guard
    always @(posedge core_clk)
    begin
        ref_div      <= ref_div + 2'h1;
        ref_clock_in <= ref_div[1];
        cycles       <= cycles + 1;
        if (cycles == 30000)
        begin
            errors = errors + 1;
            results();
        end
    end

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1;
        rd_val = rdata;
    endtask

    task automatic wait_restart(output int n);
        n = 0;
        while (osc_restart !== 1'b1 && n < 1200)
        begin
            @(posedge core_clk);
            #1;
            n = n + 1;
        end
    endtask

    task automatic t_reset_values();
        reg_rd(RES_RANGE_ADDR);
        check("res_range_settings", rd_val, RES_RANGE_RST);
        reg_rd(DIGITAL_ADDR);
        check("digital_settings", rd_val, DIGITAL_RST);
        reg_rd(8'h7E);
        check("unmapped", rd_val, ZERO8);
        check("res_range_max", res_range_max, 2'h0);
    endtask

    task automatic t_family_ident();
        reg_rd(FAMILY_IDENT_ADDR);
        check("family_ident_reg", rd_val, FAMILY_CODE_DEFAULT);
        reg_wr(FAMILY_IDENT_ADDR, 8'hC3);
        reg_rd(FAMILY_IDENT_ADDR);
        check("family_ident_wr", rd_val, FAMILY_CODE_DEFAULT);
        reg_rd(RES_RANGE_ADDR);
        check("after_ident", rd_val, RES_RANGE_RST);
    endtask

    task automatic t_res_range();
        logic [7:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v = {i[0], 1'b0, i[1:0], 4'h5};
            reg_wr(RES_RANGE_ADDR, v);
            @(posedge core_clk);
            #1;
            check("res_range_max", res_range_max, i[1:0]);
            check("res_max_disable", res_max_disable, i[0]);
        end
    endtask

    task automatic t_host_prep();
        reg_wr(SECONDARY_ADDR, 8'h01);
        reg_wr(SECONDARY_ADDR, 8'h00);
        reg_wr(AMP_OK_ADDR, 8'h00);
        reg_rd(SECONDARY_ADDR);
        check("secondary_settings", rd_val, ZERO8);
        reg_rd(AMP_OK_ADDR);
        check("amp_ok_report_ctl", rd_val, ZERO8);
    endtask

    task automatic t_res_result();
        @(posedge core_clk);
        res_valid  <= 1'b1;
        res_sample <= 16'hA55A;
        @(posedge core_clk);
        res_valid  <= 1'b0;
        reg_rd(RES_LSB_ADDR);
        check("resistance_lsb", rd_val, 8'h5A);
        reg_rd(RES_MSB_ADDR);
        check("resistance_msb", rd_val, 8'hA5);
    endtask

    task automatic t_inductance();
        int n;
        logic [15:0] ind;
        reg_wr(DIGITAL_ADDR, 8'hF0);
        @(posedge core_clk);
        #1;
        check("osc_start_sel", osc_start_sel, 4'hF);
        @(posedge core_clk);
        run         <= 1'b1;
        active_mode <= 1'b1;
        n = 0;
        while (conv_busy !== 1'b1 && n < 2000) begin @(posedge core_clk); #1; n++; end
        n = 0;
        while (conv_busy !== 1'b0 && n < 3000) begin @(posedge core_clk); #1; n++; end
        // The divider needs 33 cycles after the window closes
        repeat (40) @(posedge core_clk);
        // 192 sensor cycles of 8 core cycles hold 384 reference edges
        reg_rd(IND_LSB_ADDR);
        ind[7:0] = rd_val;
        reg_rd(IND_MSB_ADDR);
        ind[15:8] = rd_val;
        check("inductance_range", ind >= 16'd126 && ind <= 16'd129, 1'b1);
    endtask

    task automatic t_stall_abort();
        int n;
        @(posedge core_clk);
        hr_valid  <= 1'b1;
        hr_sample <= 24'h123456;
        @(posedge core_clk);
        hr_valid  <= 1'b0;
        reg_rd(HR_B0_ADDR);
        check("high_res_b0", rd_val, 8'h56);
        n = 0;
        while (conv_busy !== 1'b1 && n < 3000) begin @(posedge core_clk); #1; n++; end
        run <= 1'b0;
        wait_restart(n);
        check("stall_wait", n >= 240 && n <= 253, 1'b1);
        @(posedge core_clk);
        #1;
        check("conv_abort", conv_busy, 1'b0);
        n = 1;
        while (osc_restart === 1'b1 && n < 300) begin @(posedge core_clk); #1; n++; end
        check("restart_len", n, 24'd125);
        reg_rd(STATUS_ADDR);
        check("osc_stall_flag", rd_val[STALL_BIT], 1'b1);
        reg_rd(STATUS_ADDR);
        check("stall_cleared", rd_val[STALL_BIT], 1'b0);
        reg_rd(HR_B0_ADDR);
        check("high_res_b0", rd_val, 8'hFF);
        reg_rd(HR_B1_ADDR);
        check("high_res_b1", rd_val, 8'hFF);
        reg_rd(HR_B2_ADDR);
        check("high_res_b2", rd_val, 8'hFF);
    endtask

    task automatic t_min_sensor_freq_sel_scale();
        int n;
        run <= 1'b1;
        repeat (400) @(posedge core_clk);
        reg_wr(DIGITAL_ADDR, 8'hE0);
        run <= 1'b0;
        wait_restart(n);
        // One step lower doubles the wait to 500 cycles
        check("stall_wait_slow", n >= 488 && n <= 505, 1'b1);
    endtask

    task automatic results();
        $display("Checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset_values();
        t_family_ident();
        t_res_range();
        t_host_prep();
        t_res_result();
        t_inductance();
        t_stall_abort();
        t_min_sensor_freq_sel_scale();
        results();
    end
endmodule // sensor_osc_watchdog_results_tb_top
